// *** hw/mpu_defs.svh ***
`ifndef MPU_DEFS_SVH
`define MPU_DEFS_SVH

// Register window on the private peripheral bus
`define MPU_BASE_ADDR   32'he000ed90
`define MPU_SPAN_MASK   32'hffff_ffe0
`define OFS_TYPE        8'h00
`define OFS_CTRL        8'h04
`define OFS_RNUM        8'h08
`define OFS_RBASE       8'h0c
`define OFS_RATTR       8'h10
`define OFS_FSTAT       8'h14
`define OFS_FADDR       8'h18
`define OFS_FMASK       8'h1c

// Reset values
`define TYPE_VALUE      32'h0000_0800
`define CTRL_RESET      32'h0000_0000
`define RATTR_RESET     32'h0000_0000
`define RBASE_RESET     32'h0000_0000

// Control fields
`define CTRL_EN_BIT     0
`define CTRL_BG_BIT     2
`define CTRL_MASK       32'h0000_0005

// Region attribute and size fields
`define ATTR_XN_BIT     28
`define ATTR_AP_HI      26
`define ATTR_AP_LO      24
`define ATTR_TEX_HI     21
`define ATTR_TEX_LO     19
`define ATTR_S_BIT      18
`define ATTR_C_BIT      17
`define ATTR_B_BIT      16
`define ATTR_SRD_HI     15
`define ATTR_SRD_LO     8
`define ATTR_SIZE_HI    5
`define ATTR_SIZE_LO    1
`define ATTR_EN_BIT     0
`define ATTR_MASK       32'h17ff_ff3f
`define SIZE_MIN        5'h04
`define SIZE_SUB_MIN    5'h07
`define BASE_MASK       32'hffff_ffe0

// Fault status fields
`define FST_W           3
`define FST_FETCH_BIT   0
`define FST_DATA_BIT    1
`define FST_NOREG_BIT   2
`define FST_RESET       3'h0

`endif

// *** hw/mpu_pkg.sv ***
package mpu_pkg;

	typedef enum logic [1:0] {
		ACC_FETCH = 2'h0,
		ACC_READ  = 2'h1,
		ACC_WRITE = 2'h2
	} access_kind_type;

	typedef enum logic [1:0] {
		MEM_STRONG = 2'h0,
		MEM_DEVICE = 2'h1,
		MEM_NORMAL = 2'h2,
		MEM_RSVD   = 2'h3
	} mem_kind_type;

	typedef enum logic [1:0] {
		POL_NC   = 2'h0,
		POL_WBWA = 2'h1,
		POL_WT   = 2'h2,
		POL_WB   = 2'h3
	} cache_policy_type;

	typedef struct packed {
		logic            valid;
		logic [31:0]     addr;
		access_kind_type kind;
		logic            priv;
	} access_req_type;

	typedef struct packed {
		mem_kind_type     mkind;
		logic             shareable;
		logic             ordered;
		cache_policy_type inner_cache_policy;
		cache_policy_type outer_cache_policy;
		logic             reserved;
	} mem_attr_type;

endpackage : mpu_pkg

// *** hw/region_memory_protection_unit.sv ***
// Chosen here: the address map and the address-and-strobe port.
`include "mpu_defs.svh"
// Operation
// RULE_01: Eight numbered regions plus one background region, each with own attributes.
// RULE_02: Overlapping matches take the attributes of the highest numbered region.
// RULE_03: Background region uses default map attributes, privileged access only.
// RULE_04: Fetches and data accesses share one unified region map.
// RULE_05: A prohibited access raises a memory management fault, not completion.
// RULE_06: Type, cache, buffer, share, permission and never-execute fields govern access.
// RULE_07: Type 000 decodes strongly-ordered, shared device, write-through, write-back.
// RULE_08: Type 001 decodes non-cacheable normal or a reserved encoding.
// RULE_09: Strongly-ordered and device encodings ignore the shareable bit.
// RULE_10: Type top bit set means cached normal with outer and inner policies.
// RULE_11: Policy codes: non-cacheable, write-back allocate, write-through, write-back.
// RULE_12: Fault cause is recorded in the fault status field.
// RULE_13: Capability register at the fixed bus address shows unit presence.
// RULE_14: Strongly-ordered regions are ordered and always treated as shared.
// RULE_15: Decoded type, shareability and cache attributes go out with each access.
// RULE_16: Privileged registers accept only privileged accesses from the master.
// RULE_17: Permission code decode from no access through read-only for all.
// RULE_18: Privilege and access kind checked against permission; no fetch from never-execute.
// RULE_19: No matching region and no background grant faults the request.
module region_memory_protection_unit #(
	parameter int REGIONS = 8
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// Register port
	input  wire logic [31:0]            reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic                   reg_priv,
	output logic      [31:0]            reg_rdata,
	// Access check
	input  wire mpu_pkg::access_req_type acc_req,
	output logic                        chk_valid,
	output logic                        chk_fault,
	output mpu_pkg::mem_attr_type       chk_attr,
	// Interrupt
	output logic                        fault_irq
);

	localparam int RW = $clog2(REGIONS);

	logic [31:0]           ctrl_r;
	logic [RW-1:0]         rnum_r;
	logic [31:0]           rbase_r [REGIONS];
	logic [31:0]           rattr_r [REGIONS];
	logic [`FST_W-1:0]     fstat_r;
	logic [`FST_W-1:0]     fmask_r;
	logic [31:0]           faddr_r;
	logic [31:0]           rdata_r;
	logic                  chk_valid_r;
	logic                  chk_fault_r;
	mpu_pkg::mem_attr_type chk_attr_r;

	logic [31:0]           rel_addr;
	logic                  reg_sel;
	logic [7:0]            ofs;
	logic                  wr_ok;
	logic                  rd_ok;
	logic [REGIONS-1:0]    hit;
	logic [RW-1:0]         win;
	logic                  any_hit;
	logic [31:0]           win_attr;
	logic                  allowed;
	logic                  no_region;
	logic                  fault_now;
	mpu_pkg::mem_attr_type attr_now;
	logic [`FST_W-1:0]     fst_set;
	logic [31:0]           rdata_nxt;

	// Bus decode; unprivileged accesses are ignored and read zero
	assign rel_addr = reg_addr - `MPU_BASE_ADDR;
	assign reg_sel  = ((rel_addr & `MPU_SPAN_MASK) == 32'h0) && (rel_addr[1:0] == 2'h0);
	assign ofs      = rel_addr[7:0];
	assign wr_ok    = reg_wr && reg_sel && reg_priv; // RULE_16
	assign rd_ok    = reg_rd && reg_sel && reg_priv; // RULE_16

	// Memory type decode from type extension, cacheable, bufferable, shareable
	function automatic mpu_pkg::mem_attr_type decode_attr(input logic [2:0] type_extension_field,
			input logic c, input logic b, input logic s);
		mpu_pkg::mem_attr_type a;
		a = '{mkind: mpu_pkg::MEM_RSVD, shareable: 1'b0, ordered: 1'b0,
			inner_cache_policy: mpu_pkg::POL_NC, outer_cache_policy: mpu_pkg::POL_NC,
			reserved: 1'b1};
		if (type_extension_field[2]) begin
			// Cached normal memory, low type bits are the outer policy
			a.mkind              = mpu_pkg::MEM_NORMAL; // RULE_10
			a.outer_cache_policy = mpu_pkg::cache_policy_type'(type_extension_field[1:0]); // RULE_11
			a.inner_cache_policy = mpu_pkg::cache_policy_type'({c, b}); // RULE_11
			a.shareable          = s; // RULE_10
			a.reserved           = 1'b0;
		end else begin
			case ({type_extension_field[1:0], c, b})
				4'h0: begin
					a.mkind     = mpu_pkg::MEM_STRONG; // RULE_07
					a.shareable = 1'b1; // RULE_14
					a.ordered   = 1'b1; // RULE_14
					a.reserved  = 1'b0;
				end
				4'h1: begin
					a.mkind     = mpu_pkg::MEM_DEVICE; // RULE_07
					a.shareable = 1'b1; // RULE_09
					a.reserved  = 1'b0;
				end
				4'h2: begin
					a.mkind              = mpu_pkg::MEM_NORMAL; // RULE_07
					a.inner_cache_policy = mpu_pkg::POL_WT;
					a.outer_cache_policy = mpu_pkg::POL_WT;
					a.shareable          = s;
					a.reserved           = 1'b0;
				end
				4'h3: begin
					a.mkind              = mpu_pkg::MEM_NORMAL; // RULE_07
					a.inner_cache_policy = mpu_pkg::POL_WB;
					a.outer_cache_policy = mpu_pkg::POL_WB;
					a.shareable          = s;
					a.reserved           = 1'b0;
				end
				4'h5: begin
					a.mkind     = mpu_pkg::MEM_NORMAL; // RULE_08
					a.shareable = s;
					a.reserved  = 1'b0;
				end
				4'h8: begin
					a.mkind     = mpu_pkg::MEM_DEVICE; // RULE_09
					a.shareable = 1'b0;
					a.reserved  = 1'b0;
				end
				default: begin
					a.reserved = 1'b1; // RULE_08
				end
			endcase
		end
		return a;
	endfunction : decode_attr

	// Default memory map attributes by top address bits
	function automatic mpu_pkg::mem_attr_type default_attr(input logic [2:0] seg);
		mpu_pkg::mem_attr_type a;
		case (seg)
			3'h0:    a = decode_attr(3'h0, 1'b1, 1'b0, 1'b0);
			3'h1:    a = decode_attr(3'h5, 1'b0, 1'b1, 1'b1);
			3'h2:    a = decode_attr(3'h0, 1'b0, 1'b1, 1'b0);
			3'h3:    a = decode_attr(3'h5, 1'b0, 1'b1, 1'b0);
			3'h4:    a = decode_attr(3'h0, 1'b1, 1'b0, 1'b0);
			3'h5:    a = decode_attr(3'h0, 1'b0, 1'b1, 1'b0);
			3'h6:    a = decode_attr(3'h2, 1'b0, 1'b0, 1'b0);
			default: a = decode_attr(3'h0, 1'b0, 1'b0, 1'b0);
		endcase
		return a;
	endfunction : default_attr

	// Permission decode; reserved code 100 is treated as no access
	function automatic logic perm_ok(input logic [2:0] ap, input logic priv,
			input mpu_pkg::access_kind_type kind);
		logic wr;
		logic ok;
		wr = (kind == mpu_pkg::ACC_WRITE);
		case (ap)
			3'h1:    ok = priv;
			3'h2:    ok = priv || !wr;
			3'h3:    ok = 1'b1;
			3'h5:    ok = priv && !wr;
			3'h6:    ok = !wr;
			3'h7:    ok = !wr;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : perm_ok

	// Per region storage and address match; one map for fetch and data
	genvar gi;
	generate
		for (gi = 0; gi < REGIONS; gi++) begin : g_region
			logic [4:0]  sz;
			logic [31:0] msk;
			logic [4:0]  sub_sh;
			logic [2:0]  sub_idx;
			logic [7:0]  srd;
			logic        sub_off;

			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					rbase_r[gi] <= `RBASE_RESET;
					rattr_r[gi] <= `RATTR_RESET;
				end else if (wr_ok && rnum_r == RW'(gi)) begin
					if (ofs == `OFS_RBASE) begin
						rbase_r[gi] <= reg_wdata & `BASE_MASK; // RULE_01
					end
					if (ofs == `OFS_RATTR) begin
						rattr_r[gi] <= reg_wdata & `ATTR_MASK; // RULE_01
					end
				end
			end

			assign sz      = rattr_r[gi][`ATTR_SIZE_HI:`ATTR_SIZE_LO];
			assign msk     = 32'hffff_ffff << ({1'b0, sz} + 6'h01);
			assign sub_sh  = sz - 5'h02;
			assign sub_idx = 3'(acc_req.addr >> sub_sh);
			assign srd     = rattr_r[gi][`ATTR_SRD_HI:`ATTR_SRD_LO];
			// Subregions exist only from 256 bytes upward
			assign sub_off = (sz >= `SIZE_SUB_MIN) && srd[sub_idx];
			assign hit[gi] = rattr_r[gi][`ATTR_EN_BIT] && (sz >= `SIZE_MIN) &&
				(((acc_req.addr ^ rbase_r[gi]) & msk) == 32'h0) && !sub_off; // RULE_04
		end
	endgenerate

	// Highest numbered matching region wins
	always_comb begin
		win     = '0;
		any_hit = 1'b0;
		for (int i = 0; i < REGIONS; i++) begin
			if (hit[i]) begin
				win     = RW'(i); // RULE_02
				any_hit = 1'b1;
			end
		end
	end

	assign win_attr = rattr_r[win];

	// Access verdict and exported attributes
	always_comb begin
		allowed   = 1'b1;
		no_region = 1'b0;
		attr_now  = default_attr(acc_req.addr[31:29]);
		if (ctrl_r[`CTRL_EN_BIT]) begin
			if (any_hit) begin
				attr_now = decode_attr(win_attr[`ATTR_TEX_HI:`ATTR_TEX_LO],
					win_attr[`ATTR_C_BIT], win_attr[`ATTR_B_BIT],
					win_attr[`ATTR_S_BIT]); // RULE_06
				allowed  = perm_ok(win_attr[`ATTR_AP_HI:`ATTR_AP_LO], acc_req.priv,
					acc_req.kind) && // RULE_17
					!(acc_req.kind == mpu_pkg::ACC_FETCH && win_attr[`ATTR_XN_BIT]); // RULE_18
			end else begin
				allowed   = ctrl_r[`CTRL_BG_BIT] && acc_req.priv; // RULE_03
				no_region = 1'b1; // RULE_19
			end
		end
	end

	assign fault_now = acc_req.valid && !allowed; // RULE_05

	always_comb begin
		fst_set = '0;
		if (fault_now) begin
			fst_set[`FST_FETCH_BIT] = (acc_req.kind == mpu_pkg::ACC_FETCH); // RULE_12
			fst_set[`FST_DATA_BIT]  = (acc_req.kind != mpu_pkg::ACC_FETCH); // RULE_12
			fst_set[`FST_NOREG_BIT] = no_region; // RULE_12
		end
	end

	// Verdict registered one cycle after the request
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chk_valid_r <= 1'b0;
			chk_fault_r <= 1'b0;
			chk_attr_r  <= '0;
		end else begin
			chk_valid_r <= acc_req.valid;
			chk_fault_r <= fault_now; // RULE_05
			chk_attr_r  <= attr_now; // RULE_15
		end
	end

	// Control, region number, mask
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r  <= `CTRL_RESET;
			rnum_r  <= '0;
			fmask_r <= '0;
		end else if (wr_ok) begin
			case (ofs)
				`OFS_CTRL:  ctrl_r  <= reg_wdata & `CTRL_MASK;
				`OFS_RNUM:  rnum_r  <= reg_wdata[RW-1:0];
				`OFS_FMASK: fmask_r <= reg_wdata[`FST_W-1:0];
				default:    ctrl_r  <= ctrl_r;
			endcase
		end
	end

	// Sticky fault status, write one to clear; a new fault beats the clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fstat_r <= `FST_RESET;
		end else if (wr_ok && ofs == `OFS_FSTAT) begin
			fstat_r <= (fstat_r & ~reg_wdata[`FST_W-1:0]) | fst_set; // RULE_12
		end else begin
			fstat_r <= fstat_r | fst_set; // RULE_12
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			faddr_r <= 32'h0;
		end else if (fault_now) begin
			faddr_r <= acc_req.addr; // RULE_12
		end
	end

	// Read mux; unmapped or unprivileged reads return zero
	always_comb begin
		rdata_nxt = 32'h0;
		if (rd_ok) begin
			case (ofs)
				`OFS_TYPE:  rdata_nxt = `TYPE_VALUE; // RULE_13
				`OFS_CTRL:  rdata_nxt = ctrl_r;
				`OFS_RNUM:  rdata_nxt = 32'(rnum_r);
				`OFS_RBASE: rdata_nxt = rbase_r[rnum_r];
				`OFS_RATTR: rdata_nxt = rattr_r[rnum_r];
				`OFS_FSTAT: rdata_nxt = 32'(fstat_r);
				`OFS_FADDR: rdata_nxt = faddr_r;
				`OFS_FMASK: rdata_nxt = 32'(fmask_r);
				default:    rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign chk_valid = chk_valid_r;
	assign chk_fault = chk_fault_r;
	assign chk_attr  = chk_attr_r;
	assign fault_irq = |(fstat_r & fmask_r);

	// Checks
	a_no_match_fault: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_19
		acc_req.valid && ctrl_r[`CTRL_EN_BIT] && !any_hit &&
		!(ctrl_r[`CTRL_BG_BIT] && acc_req.priv) |=> chk_fault && chk_valid)
		else $error("unmatched access did not fault");

	a_bg_unpriv: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_03
		acc_req.valid && ctrl_r[`CTRL_EN_BIT] && !any_hit && !acc_req.priv |=> chk_fault)
		else $error("background region granted unprivileged access");

	a_xn_fetch: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_18
		acc_req.valid && ctrl_r[`CTRL_EN_BIT] && any_hit && win_attr[`ATTR_XN_BIT] &&
		acc_req.kind == mpu_pkg::ACC_FETCH |=> chk_fault)
		else $error("fetch from never-execute region allowed");

	a_ap_none: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_17
		acc_req.valid && ctrl_r[`CTRL_EN_BIT] && any_hit &&
		win_attr[`ATTR_AP_HI:`ATTR_AP_LO] == 3'h0 |=> chk_fault)
		else $error("no-access region allowed an access");

	a_highest_wins: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_02
		hit[REGIONS-1] |-> win == RW'(REGIONS-1))
		else $error("top region did not take precedence");

	a_strong_shared: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_14
		chk_valid && chk_attr.mkind == mpu_pkg::MEM_STRONG |-> chk_attr.shareable &&
		chk_attr.ordered)
		else $error("strongly-ordered access not shared and ordered");

	a_status_data: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_12
		fault_now && acc_req.kind != mpu_pkg::ACC_FETCH ##1 chk_fault |->
		fstat_r[`FST_DATA_BIT] && faddr_r == $past(acc_req.addr))
		else $error("data fault cause or address not recorded");

	a_irq_follow: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_05
		fault_now && fmask_r[`FST_NOREG_BIT] && no_region && !wr_ok |=> fault_irq)
		else $error("masked-in fault did not raise interrupt");

	a_type_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_13
		reg_rd && reg_priv && reg_addr == `MPU_BASE_ADDR |=> reg_rdata == `TYPE_VALUE)
		else $error("capability register read wrong");

	a_unpriv_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_16
		reg_rd && !reg_priv |=> reg_rdata == 32'h0)
		else $error("unprivileged register read returned data");

	a_off_passes: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_05
		acc_req.valid && !ctrl_r[`CTRL_EN_BIT] |=> !chk_fault)
		else $error("disabled unit faulted an access");

endmodule : region_memory_protection_unit

// *** verification/core_access_model.sv ***
module core_access_model (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	// Commands from the bench
	input  wire logic                     cmd_valid,
	input  wire logic [31:0]              cmd_addr,
	input  wire mpu_pkg::access_kind_type cmd_kind,
	input  wire logic                     cmd_priv,
	// Request towards the protection unit
	output mpu_pkg::access_req_type       acc_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle cycles scramble address and privilege so a stale request never looks live
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_req <= '0;
		end else begin
			acc_req.valid <= cmd_valid;
			acc_req.addr  <= cmd_valid ? cmd_addr : ~acc_req.addr;
			acc_req.kind  <= cmd_kind;
			acc_req.priv  <= cmd_valid ? cmd_priv : ~acc_req.priv;
		end
	end
endmodule : core_access_model

// *** verification/region_memory_protection_unit_tb_top.sv ***
`include "mpu_defs.svh"
module region_memory_protection_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     sys_clk = 1'b0;
	logic                     sys_rst = 1'b1;
	logic [31:0]              reg_addr = 32'h0, reg_wdata = 32'h0;
	logic                     reg_wr = 1'b0, reg_rd = 1'b0, reg_priv = 1'b0;
	logic [31:0]              reg_rdata;
	logic                     cmd_valid = 1'b0, cmd_priv = 1'b0;
	logic [31:0]              cmd_addr = 32'h0;
	mpu_pkg::access_kind_type cmd_kind = mpu_pkg::ACC_READ;
	mpu_pkg::access_req_type  acc_req;
	logic                     chk_valid, chk_fault, fault_irq;
	mpu_pkg::mem_attr_type    chk_attr;
	// Reference state
	logic [31:0]              ctrl_m = 32'h0, rnum_m = 32'h0, fst_m = 32'h0;
	logic [31:0]              faddr_m = 32'h0, msk_m = 32'h0;
	logic [31:0]              base_m [8] = '{default: 32'h0};
	logic [31:0]              attr_m [8] = '{default: 32'h0};
	logic [31:0]              rdq [$];
	logic [8:0]               e_attr, e_mask, pat, pm;
	logic [2:0]               e_cause, pc;
	logic                     e_fault, pf, rd_v = 1'b0, ev = 1'b0;
	logic [31:0]              pa, at;
	logic                     pr;
	int                       err_count = 0;
	int                       samples_checked = 0;

	core_access_model u_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_addr(cmd_addr), .cmd_kind(cmd_kind), .cmd_priv(cmd_priv), .acc_req(acc_req));
	region_memory_protection_unit #(.REGIONS(8)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_priv(reg_priv), .reg_rdata(reg_rdata), .acc_req(acc_req), .chk_valid(chk_valid),
		.chk_fault(chk_fault), .chk_attr(chk_attr), .fault_irq(fault_irq));

	always #10 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	function automatic logic [31:0] reg_exp(input logic [7:0] o, input logic p);
		if (!p || o > 8'h1c || o[1:0] != 2'h0) return 32'h0;
		case (o)
			`OFS_TYPE: return `TYPE_VALUE;
			`OFS_CTRL: return ctrl_m;
			`OFS_RNUM: return rnum_m;
			`OFS_RBASE: return base_m[rnum_m[2:0]];
			`OFS_RATTR: return attr_m[rnum_m[2:0]];
			`OFS_FSTAT: return fst_m;
			`OFS_FADDR: return faddr_m;
			default: return msk_m;
		endcase
	endfunction : reg_exp

	// Shareability of type-000 normal memory is left unchecked: its reading is open
	function automatic void mk(input logic [1:0] mt, input logic sh, input logic [1:0] pi,
			input logic [1:0] po, input logic res, input logic csh);
		e_attr = {mt, sh, mt == 2'h0, pi, po, res};
		if (res) e_mask = 9'h001;
		else if (mt == 2'h2) e_mask = csh ? 9'h1ff : 9'h1bf;
		else e_mask = (mt == 2'h0) ? 9'h1e1 : 9'h1c1;
	endfunction : mk

	function automatic void dmap(input logic [2:0] s);
		case (s)
			3'h0, 3'h4: mk(2'h2, 1'b0, 2'h2, 2'h2, 1'b0, 1'b0);
			3'h1: mk(2'h2, 1'b1, 2'h1, 2'h1, 1'b0, 1'b1);
			3'h3: mk(2'h2, 1'b0, 2'h1, 2'h1, 1'b0, 1'b0);
			3'h2, 3'h5: mk(2'h1, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
			3'h6: mk(2'h1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0);
			default: mk(2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
		endcase
	endfunction : dmap

	function automatic void predict(input logic [31:0] a, input logic [1:0] k, input logic p);
		int hit;
		int sz;
		logic [31:0] r;
		logic [2:0] ap;
		logic ok;
		hit = -1;
		for (int i = 0; i < 8; i++) begin
			sz = attr_m[i][5:1];
			if (attr_m[i][0] && sz >= 4 && ((a ^ base_m[i]) >> (sz + 1)) == 0
				&& !(sz >= 7 && attr_m[i][8 + ((a >> (sz - 2)) & 7)])) hit = i;
		end
		e_fault = 1'b0;
		e_cause = (k == 2'h0) ? 3'h1 : 3'h2;
		if (!ctrl_m[0] || (hit < 0 && ctrl_m[2] && p)) begin
			dmap(a[31:29]);
		end else if (hit < 0) begin
			e_fault = 1'b1;
			e_cause = e_cause | 3'h4;
		end else begin
			r = attr_m[hit];
			ap = r[26:24];
			if (k == 2'h2) ok = p ? (ap >= 3'h1 && ap <= 3'h3) : (ap == 3'h3);
			else ok = p ? (ap != 3'h0 && ap != 3'h4) : (ap == 3'h2 || ap == 3'h3 || ap >= 3'h6);
			e_fault = !ok || (k == 2'h0 && r[28]);
			e_cause = (k == 2'h0) ? 3'h1 : 3'h2;
			if (r[21]) mk(2'h2, r[18], r[17:16], r[20:19], 1'b0, 1'b1);
			else case ({r[21:19], r[17:16]})
				5'h00: mk(2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
				5'h01: mk(2'h1, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
				5'h02: mk(2'h2, 1'b0, 2'h2, 2'h2, 1'b0, 1'b0);
				5'h03: mk(2'h2, 1'b0, 2'h3, 2'h3, 1'b0, 1'b0);
				5'h08: mk(2'h0, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0);
				5'h09: mk(2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0);
				5'h10: mk(2'h1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0);
				default: e_mask = 9'h000;
			endcase
		end
	endfunction : predict

	task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] d, input logic p);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= `MPU_BASE_ADDR + 32'(o);
		reg_wdata <= d;
		reg_priv <= p;
		if (!w) rdq.push_back(reg_exp(o, p));
		@(posedge sys_clk);
		if (w && p && o <= 8'h1c && o[1:0] == 2'h0) case (o)
			`OFS_CTRL: ctrl_m = d & `CTRL_MASK;
			`OFS_RNUM: rnum_m = d & 32'h7;
			`OFS_RBASE: base_m[rnum_m[2:0]] = d & `BASE_MASK;
			`OFS_RATTR: attr_m[rnum_m[2:0]] = d & `ATTR_MASK;
			`OFS_FSTAT: fst_m = fst_m & ~(d & 32'h7);
			`OFS_FMASK: msk_m = d & 32'h7;
			default: ;
		endcase
	endtask : bus

	// Two idle edges let fault status settle before a register read is predicted
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		cmd_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : idle

	task automatic acc(input int n);
		repeat (n) begin
			cmd_valid <= $urandom_range(3) != 0;
			cmd_addr <= ($urandom_range(3) == 0) ? $urandom : (32'h2000_0000 | ($urandom & 32'h1fff));
			cmd_kind <= mpu_pkg::access_kind_type'($urandom_range(2));
			cmd_priv <= $urandom_range(1);
			@(posedge sys_clk);
		end
	endtask : acc

	always @(posedge sys_clk) begin
		rd_v <= reg_rd;
		ev <= acc_req.valid;
		if (acc_req.valid) begin
			predict(acc_req.addr, acc_req.kind, acc_req.priv);
			pf <= e_fault;
			pc <= e_cause;
			pat <= e_attr;
			pm <= e_mask;
			pa <= acc_req.addr;
		end
	end

	always @(negedge sys_clk) begin
		if (!sys_rst) begin
			chk(chk_valid, ev);
			if (ev) begin
				chk(chk_fault, pf);
				if (!pf) chk({23'h0, chk_attr} & pm, {23'h0, pat} & pm);
				if (pf) fst_m = fst_m | pc;
				if (pf) faddr_m = pa;
			end
			if (rd_v) chk(reg_rdata, rdq.pop_front());
			else chk(reg_rdata, 32'h0);
			chk(fault_irq, |(fst_m & msk_m));
		end
	end

	initial begin
		#200000;
		err_count++;
		stop_test();
	end

	initial begin
		void'($urandom(70));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (int o = 0; o < 36; o++) bus(1'b0, 8'(o), 32'h0, $urandom_range(3) != 0);
		idle();
		acc(40);
		idle();
		for (int it = 0; it < 50; it++) begin
			pr = $urandom_range(7) != 0;
			at = $urandom & `ATTR_MASK;
			at[5:1] = 5'h04 + 5'($urandom_range(7));
			if (at[5:1] < `SIZE_SUB_MIN) at[15:8] = 8'h00;
			at[0] = $urandom_range(3) != 0;
			bus(1'b1, `OFS_RNUM, $urandom, pr);
			bus(1'b1, `OFS_RBASE, 32'h2000_0000 | ($urandom & 32'h1fff), pr);
			bus(1'b1, `OFS_RATTR, at, pr);
			bus(1'b1, `OFS_CTRL, $urandom, pr);
			bus(1'b1, `OFS_FMASK, $urandom, 1'b1);
			bus(1'b0, 8'($urandom_range(35)), 32'h0, pr);
			idle();
			acc(30);
			idle();
			bus(1'b0, `OFS_FSTAT, 32'h0, 1'b1);
			bus(1'b0, `OFS_FADDR, 32'h0, 1'b1);
			bus(1'b1, `OFS_FSTAT, $urandom, 1'b1);
			bus(1'b0, `OFS_FSTAT, 32'h0, 1'b1);
			idle();
		end
		stop_test();
	end
endmodule : region_memory_protection_unit_tb_top
